// >>> rfc_params.svh
// Constants of the receive frame filter: register indexes, field positions,
// reset values and frame-layout lengths.
// Assumes inclusion by bare name from every file that needs a figure.
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH

// Register indexes; byte address is four times the index
`define RFC_IDX_EUI_LO  8'h01
`define RFC_IDX_PANADR  8'h03
`define RFC_IDX_SYSCFG  8'h04
`define RFC_IDX_EUI_HI  8'h40
`define RFC_IDX_STATUS  8'h41

// Configuration field positions
`define RFC_FILTER_ON   0
`define RFC_COORD       1
`define RFC_ACC_BEACON  2
`define RFC_ACC_DATA    3
`define RFC_ACC_ACK     4
`define RFC_ACC_CMD     5
`define RFC_ACC_RSVD    6
`define RFC_ACC_T4      7
`define RFC_ACC_T5      8
`define RFC_CFG_MASK    32'h0000_01ff

// Reset values
`define RFC_SYSCFG_RST  32'h0000_0000
`define RFC_PANADR_RST  32'hffff_ffff
`define RFC_EUI_RST     64'h0000_0000_0000_0000

// Frame control field positions
`define RFC_FC_PANC     6
`define RFC_FC_DMODE_LO 10
`define RFC_FC_SMODE_LO 14
`define RFC_BCAST       16'hffff

// Octet lengths of frame parts
`define RFC_LEN_FC      7'h02
`define RFC_LEN_SEQ     7'h01
`define RFC_LEN_PAN     7'h02
`define RFC_LEN_SHORT   7'h02
`define RFC_LEN_EXT     7'h08
`define RFC_LEN_FCS     7'h02

`endif

// >>> rfc_pkg.sv
// Types shared by the receive frame filter files.
// Assumes no surroundings beyond a SystemVerilog compiler.
package rfc_pkg;

  typedef enum logic [2:0] {
    FT_BEACON = 3'b000,
    FT_DATA   = 3'b001,
    FT_ACK    = 3'b010,
    FT_CMD    = 3'b011,
    FT_T4     = 3'b100,
    FT_T5     = 3'b101,
    FT_T6     = 3'b110,
    FT_T7     = 3'b111
  } rfc_ftype_e;

  typedef enum logic [1:0] {
    AM_NONE  = 2'b00,
    AM_RSVD  = 2'b01,
    AM_SHORT = 2'b10,
    AM_EXT   = 2'b11
  } rfc_amode_e;

endpackage

// >>> rfc_bus_if.sv
// Register access carrier between the bus front end and the register bank.
// Assumes both ends run on the same clock.
interface rfc_bus_if #(parameter int ADDR_W = 12);
  logic              wr_en;
  logic [ADDR_W-1:0] addr;
  logic [31:0]       wdata;
  logic [31:0]       rdata;
  logic              hit;

  modport apb_side (output wr_en, output addr, output wdata, input rdata, input hit);
  modport reg_side (input wr_en, input addr, input wdata, output rdata, output hit);
endinterface

// >>> rfc_apb_slave.sv
// Bus front end: APB slave with one wait state on every access.
// Assumes the register bank answers rdata and hit combinationally from addr.
module rfc_apb_slave #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              arst_n_in,
  // APB
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Register bank
  rfc_bus_if.apb_side            bus
);

  logic access;

  assign access    = psel_in & penable_in & ~pready_out;
  assign bus.addr  = paddr_in;
  assign bus.wdata = pwdata_in;
  // Write lands at the edge where pready is sampled high
  assign bus.wr_en = psel_in & penable_in & pready_out & pwrite_in & bus.hit;

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pready_out  <= 1'b0;
      prdata_out  <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      pready_out  <= access;
      pslverr_out <= access & ~bus.hit;
      if (access && !pwrite_in && bus.hit) begin
        prdata_out <= bus.rdata;
      end else begin
        prdata_out <= 32'h0000_0000;
      end
    end
  end

endmodule

// >>> rfc_filter.sv
// Receive frame filter: configuration registers and per-frame verdict.
// Assumes the receive path presents decoded frame fields with a one-cycle
// strobe per frame, synchronous to sys_clk_in.
//
// What this block does
// RL1 - The system configuration register sits at index 0x04 as a 32-bit read-write bitmap.
// RL2 - Bit 0 turns filtering on, and then a frame is good only if it passes every check.
// RL3 - A present destination must match network identifier plus short address, or the 64-bit id.
// RL4 - Software should program addresses and other bits before setting the enable bit.
// RL5 - Bit 1 makes a coordinator accept frames without destination if the source network matches.
// RL6 - With bit 1 clear, a present destination that differs from ours rejects the frame.
// RL7 - The frame type is the low three bits of frame control and selects the acceptance bit.
// RL8 - Bit 2 lets beacon frames (type 000) through subject to the other checks.
// RL9 - Bit 3 lets data frames (type 001) through subject to the other checks.
// RL10 - Bit 4 lets acknowledgement frames (type 010) through with the length check only, without address checks.
// RL11 - Bit 5 lets command frames (type 011) through subject to the other checks.
// RL12 - Bits 7 and 8 accept types 4 and 5 without address checks, else bit 6 decides.
// RL13 - Bit 6 accepts all types 4 to 7 without address checks.
// RL14 - Frame control still gives a minimum length and shorter frames are rejected.
// RL15 - Writes apply to frames whose check starts after the write, and reserved bits read zero.
//
// The implementer's own choice: the APB register port.
`include "rfc_params.svh"

module rfc_filter #(
  parameter int          ADDR_W  = 12,
  parameter logic [63:0] EUI_RST = `RFC_EUI_RST
) (
  // Clock and reset
  input  wire logic              sys_clk_in,
  input  wire logic              arst_n_in,
  // APB
  input  wire logic [ADDR_W-1:0] paddr_in,
  input  wire logic              psel_in,
  input  wire logic              penable_in,
  input  wire logic              pwrite_in,
  input  wire logic [31:0]       pwdata_in,
  output logic [31:0]            prdata_out,
  output logic                   pready_out,
  output logic                   pslverr_out,
  // Decoded received frame
  input  wire logic              frm_valid_in,
  input  wire logic [15:0]       frm_fc_in,
  input  wire logic [15:0]       frm_dst_pan_in,
  input  wire logic [63:0]       frm_dst_addr_in,
  input  wire logic [15:0]       frm_src_pan_in,
  input  wire logic [6:0]        frm_len_in,
  // Verdict
  output logic                   vrd_valid_out,
  output logic                   vrd_accept_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [ADDR_W-1:0] addr_of(input logic [7:0] idx);
    addr_of = ADDR_W'({idx, 2'b00});
  endfunction

  function automatic logic [6:0] addr_len(input logic [1:0] mode);
    case (mode)
      rfc_pkg::AM_SHORT: addr_len = `RFC_LEN_SHORT;
      rfc_pkg::AM_EXT:   addr_len = `RFC_LEN_EXT;
      default:           addr_len = 7'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Bus front end

  rfc_bus_if #(.ADDR_W(ADDR_W)) bus ();

  rfc_apb_slave #(.ADDR_W(ADDR_W)) u_apb (
    .sys_clk_in  (sys_clk_in),
    .arst_n_in   (arst_n_in),
    .paddr_in    (paddr_in),
    .psel_in     (psel_in),
    .penable_in  (penable_in),
    .pwrite_in   (pwrite_in),
    .pwdata_in   (pwdata_in),
    .prdata_out  (prdata_out),
    .pready_out  (pready_out),
    .pslverr_out (pslverr_out),
    .bus         (bus)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  logic [31:0] cfg_q;
  logic [31:0] panadr_q;
  logic [63:0] eui_q;
  logic [15:0] acc_cnt_q;
  logic [15:0] rej_cnt_q;
  logic [15:0] own_pan;
  logic [15:0] own_short;

  assign own_pan   = panadr_q[31:16];
  assign own_short = panadr_q[15:0];

  // RL1 configuration write path
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= `RFC_SYSCFG_RST;
    end else if (bus.wr_en && bus.addr == addr_of(`RFC_IDX_SYSCFG)) begin
      // RL15 reserved bits dropped
      cfg_q <= bus.wdata & `RFC_CFG_MASK;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      panadr_q <= `RFC_PANADR_RST;
    end else if (bus.wr_en && bus.addr == addr_of(`RFC_IDX_PANADR)) begin
      panadr_q <= bus.wdata;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      eui_q <= EUI_RST;
    end else if (bus.wr_en && bus.addr == addr_of(`RFC_IDX_EUI_LO)) begin
      eui_q[31:0] <= bus.wdata;
    end else if (bus.wr_en && bus.addr == addr_of(`RFC_IDX_EUI_HI)) begin
      eui_q[63:32] <= bus.wdata;
    end
  end

  // Read decode
  always_comb begin
    bus.hit   = 1'b1;
    bus.rdata = 32'h0000_0000;
    if (bus.addr == addr_of(`RFC_IDX_SYSCFG)) begin
      bus.rdata = cfg_q;
    end else if (bus.addr == addr_of(`RFC_IDX_PANADR)) begin
      bus.rdata = panadr_q;
    end else if (bus.addr == addr_of(`RFC_IDX_EUI_LO)) begin
      bus.rdata = eui_q[31:0];
    end else if (bus.addr == addr_of(`RFC_IDX_EUI_HI)) begin
      bus.rdata = eui_q[63:32];
    end else if (bus.addr == addr_of(`RFC_IDX_STATUS)) begin
      bus.rdata = {rej_cnt_q, acc_cnt_q};
    end else begin
      bus.hit = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame decode

  rfc_pkg::rfc_ftype_e ftype;
  logic [1:0]          dmode;
  logic [1:0]          smode;
  logic [6:0]          min_len;
  logic                len_ok;
  logic                pan_ok;
  logic                dst_ok;
  logic                pass;
  logic                accept;

  // RL7 frame type field
  assign ftype = rfc_pkg::rfc_ftype_e'(frm_fc_in[2:0]);
  assign dmode = frm_fc_in[`RFC_FC_DMODE_LO+1:`RFC_FC_DMODE_LO];
  assign smode = frm_fc_in[`RFC_FC_SMODE_LO+1:`RFC_FC_SMODE_LO];

  // RL14 minimum length from frame control
  always_comb begin
    min_len = `RFC_LEN_FC + `RFC_LEN_SEQ + `RFC_LEN_FCS + addr_len(dmode) + addr_len(smode);
    if (dmode != rfc_pkg::AM_NONE) begin
      min_len = min_len + `RFC_LEN_PAN;
    end
    if (smode != rfc_pkg::AM_NONE && !frm_fc_in[`RFC_FC_PANC]) begin
      min_len = min_len + `RFC_LEN_PAN;
    end
  end

  assign len_ok = frm_len_in >= min_len;
  assign pan_ok = frm_dst_pan_in == own_pan || frm_dst_pan_in == `RFC_BCAST;

  // Destination check
  always_comb begin
    case (dmode)
      // RL3 short address match
      rfc_pkg::AM_SHORT: begin
        dst_ok = pan_ok && (frm_dst_addr_in[15:0] == own_short ||
                            frm_dst_addr_in[15:0] == `RFC_BCAST);
      end
      // RL3 extended id match
      rfc_pkg::AM_EXT: begin
        dst_ok = pan_ok && frm_dst_addr_in == eui_q;
      end
      // RL5 coordinator takes frames without destination
      rfc_pkg::AM_NONE: begin
        dst_ok = (cfg_q[`RFC_COORD] && frm_src_pan_in == own_pan) ||
                 ftype == rfc_pkg::FT_BEACON;
      end
      default: begin
        dst_ok = 1'b0;
      end
    endcase
  end

  // Per-type acceptance
  always_comb begin
    case (ftype)
      // RL8 beacon
      rfc_pkg::FT_BEACON: pass = cfg_q[`RFC_ACC_BEACON] & dst_ok;
      // RL9 data, RL6 mismatch rejects
      rfc_pkg::FT_DATA:   pass = cfg_q[`RFC_ACC_DATA] & dst_ok;
      // RL10 acknowledgement
      rfc_pkg::FT_ACK:    pass = cfg_q[`RFC_ACC_ACK];
      // RL11 command
      rfc_pkg::FT_CMD:    pass = cfg_q[`RFC_ACC_CMD] & dst_ok;
      // RL12 types four and five
      rfc_pkg::FT_T4:     pass = cfg_q[`RFC_ACC_T4] | cfg_q[`RFC_ACC_RSVD];
      rfc_pkg::FT_T5:     pass = cfg_q[`RFC_ACC_T5] | cfg_q[`RFC_ACC_RSVD];
      // RL13 remaining reserved types
      default:            pass = cfg_q[`RFC_ACC_RSVD];
    endcase
  end

  // RL2 filter off passes everything
  assign accept = ~cfg_q[`RFC_FILTER_ON] | (len_ok & pass);

  ////////////////////////////////////////////////////////////////////////////
  // Verdict and counters

  // RL15 uses the configuration standing at the strobe
  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      vrd_valid_out  <= 1'b0;
      vrd_accept_out <= 1'b0;
    end else begin
      vrd_valid_out  <= frm_valid_in;
      vrd_accept_out <= frm_valid_in & accept;
    end
  end

  always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      acc_cnt_q <= 16'h0000;
      rej_cnt_q <= 16'h0000;
    end else if (frm_valid_in) begin
      if (accept) begin
        acc_cnt_q <= acc_cnt_q + 16'h0001;
      end else begin
        rej_cnt_q <= rej_cnt_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  logic hdr_frm;
  logic coord_src_ok;
  assign hdr_frm      = frm_valid_in & cfg_q[`RFC_FILTER_ON];
  assign coord_src_ok = cfg_q[`RFC_COORD] & (frm_src_pan_in == own_pan);

  a_cfg_write_lands: assert property ( // RL1
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    psel_in && penable_in && pready_out && pwrite_in && paddr_in == addr_of(`RFC_IDX_SYSCFG)
    |=> cfg_q == ($past(pwdata_in) & `RFC_CFG_MASK))
    else $error("configuration write not stored");

  a_cfg_rsvd_zero: assert property ( // RL15
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    psel_in && penable_in && !pwrite_in && paddr_in == addr_of(`RFC_IDX_SYSCFG)
    ##1 pready_out |-> prdata_out[31:9] == 23'h000000 && prdata_out[8:0] == cfg_q[8:0])
    else $error("configuration readback wrong");

  a_filter_off_pass: assert property ( // RL2
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    frm_valid_in && !cfg_q[`RFC_FILTER_ON] |=> vrd_valid_out && vrd_accept_out)
    else $error("frame dropped with filtering off");

  a_beacon_gate: assert property ( // RL8
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[2:0] == 3'b000 && !cfg_q[`RFC_ACC_BEACON] |=> !vrd_accept_out)
    else $error("beacon accepted while blocked");

  a_data_gate: assert property ( // RL9
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[2:0] == 3'b001 && !cfg_q[`RFC_ACC_DATA] |=> !vrd_accept_out)
    else $error("data frame accepted while blocked");

  a_ack_pass: assert property ( // RL10
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[2:0] == 3'b010 && len_ok |=> vrd_accept_out == $past(cfg_q[4]))
    else $error("acknowledgement verdict wrong");

  a_cmd_gate: assert property ( // RL11
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[2:0] == 3'b011 && !cfg_q[`RFC_ACC_CMD] |=> !vrd_accept_out)
    else $error("command frame accepted while blocked");

  a_type4_pass: assert property ( // RL12
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[2:0] == 3'b100 && len_ok && cfg_q[`RFC_ACC_T4] |=> vrd_accept_out)
    else $error("type four frame rejected");

  a_rsvd_all: assert property ( // RL13
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[2] && len_ok && cfg_q[`RFC_ACC_RSVD] |=> vrd_accept_out)
    else $error("reserved type rejected");

  a_short_frame: assert property ( // RL14
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_len_in < 7'h05 |=> vrd_valid_out && !vrd_accept_out)
    else $error("short frame accepted");

  a_node_mismatch: assert property ( // RL6
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[11:10] == 2'b10 && frm_fc_in[2:0] == 3'b001 &&
    frm_dst_addr_in[15:0] != own_short && frm_dst_addr_in[15:0] != 16'hffff
    |=> !vrd_accept_out)
    else $error("foreign destination accepted");

  a_coord_nodst: assert property ( // RL5
    @(posedge sys_clk_in) disable iff (!arst_n_in)
    hdr_frm && frm_fc_in[11:10] == 2'b00 && frm_fc_in[2:0] == 3'b001 && len_ok &&
    cfg_q[`RFC_ACC_DATA] |=> vrd_accept_out == $past(coord_src_ok))
    else $error("coordinator verdict wrong");

endmodule

// >>> rfc_rx_model.sv
////////////////////////////////////////////////////////////////////////////////
// Receive path model: hands the filter one decoded frame per strobe.
// Assumes the filter samples the fields at the rising edge that sees the strobe.
////////////////////////////////////////////////////////////////////////////////
module rfc_rx_model (
  // Clock
  input  wire logic        sys_clk_in,
  // Decoded frame
  output logic             frm_valid_out,
  output logic [15:0]      frm_fc_out,
  output logic [15:0]      frm_dst_pan_out,
  output logic [63:0]      frm_dst_addr_out,
  output logic [15:0]      frm_src_pan_out,
  output logic [6:0]       frm_len_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    frm_valid_out = 1'b0;
    frm_fc_out = 16'h0000;
    frm_dst_pan_out = 16'h0000;
    frm_dst_addr_out = 64'h0;
    frm_src_pan_out = 16'h0000;
    frm_len_out = 7'h00;
  end

  // type in frame control low bits
  task automatic put(input logic [15:0] fc, input logic [15:0] dpan, input logic [63:0] dad,
                     input logic [15:0] span, input logic [6:0] len);
    @(posedge sys_clk_in);
    frm_valid_out <= 1'b1;
    frm_fc_out <= fc;
    frm_dst_pan_out <= dpan;
    frm_dst_addr_out <= dad;
    frm_src_pan_out <= span;
    frm_len_out <= len;
  endtask

  // Released fields show the inverse of their last value, never a stale frame
  task automatic idle();
    @(posedge sys_clk_in);
    frm_valid_out <= 1'b0;
    frm_fc_out <= ~frm_fc_out;
    frm_dst_pan_out <= ~frm_dst_pan_out;
    frm_dst_addr_out <= ~frm_dst_addr_out;
    frm_src_pan_out <= ~frm_src_pan_out;
    frm_len_out <= ~frm_len_out;
  endtask
endmodule

// >>> rx_frame_filter_config_bench.sv
////////////////////////////////////////////////////////////////////////////////
// Self-checking bench of the receive frame filter: registers over APB and
// verdicts on frames sent by the receive path model.
// Assumes rfc_filter, rfc_rx_model and the constants header compile first.
////////////////////////////////////////////////////////////////////////////////
`include "rfc_params.svh"
module rx_frame_filter_config_bench;
  timeunit 1ns;
  timeprecision 1ps;

  typedef struct {
    logic [31:0] cfg;
    logic [15:0] fc;
    logic [15:0] dpan;
    logic [63:0] dad;
    logic [15:0] span;
    logic [6:0]  len;
    logic        acc;
  } rfc_row_s;

  localparam logic [11:0] A_EUL = {2'b00, `RFC_IDX_EUI_LO, 2'b00};
  localparam logic [11:0] A_PAN = {2'b00, `RFC_IDX_PANADR, 2'b00};
  localparam logic [11:0] A_CFG = {2'b00, `RFC_IDX_SYSCFG, 2'b00};
  localparam logic [11:0] A_EUH = {2'b00, `RFC_IDX_EUI_HI, 2'b00};
  localparam logic [11:0] A_STA = {2'b00, `RFC_IDX_STATUS, 2'b00};

  logic        sys_clk_in, arst_n_in, psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out, rd;
  logic        pready_out, pslverr_out, er, frm_valid_in;
  logic [15:0] frm_fc_in, frm_dst_pan_in, frm_src_pan_in;
  logic [63:0] frm_dst_addr_in;
  logic [6:0]  frm_len_in;
  logic        vrd_valid_out, vrd_accept_out;
  int          fail_count, comparisons, acc_n, rej_n;
  rfc_row_s    rows [26];

  rfc_filter #(.ADDR_W(12)) uut (.sys_clk_in, .arst_n_in, .paddr_in, .psel_in, .penable_in,
    .pwrite_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .frm_valid_in, .frm_fc_in,
    .frm_dst_pan_in, .frm_dst_addr_in, .frm_src_pan_in, .frm_len_in, .vrd_valid_out,
    .vrd_accept_out);

  rfc_rx_model m (.sys_clk_in(sys_clk_in), .frm_valid_out(frm_valid_in), .frm_fc_out(frm_fc_in),
    .frm_dst_pan_out(frm_dst_pan_in), .frm_dst_addr_out(frm_dst_addr_in),
    .frm_src_pan_out(frm_src_pan_in), .frm_len_out(frm_len_in));

  initial begin
    sys_clk_in = 1'b0;
    forever #2 sys_clk_in = ~sys_clk_in;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    penable_in <= 1'b0;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk_in);
      if (pready_out === 1'b1) break;
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    if (i == 16) begin
      fail_count++;
      tally_and_finish();
    end
  endtask

  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, e);
  endtask

  // Verdict is due exactly one cycle after the strobe edge
  task automatic verdict(input logic e);
    #1;
    check({31'h0, vrd_valid_out}, 32'h0000_0001);
    check({31'h0, vrd_accept_out}, {31'h0, e});
    if (e) acc_n++;
    else rej_n++;
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    // Frame control: type [2:0], compression [6], dst mode [11:10], src mode [15:14]
    rows = '{
      '{32'h000, 16'h8841, 16'h9999, 64'h1, 16'h0, 7'h03, 1'b1},
      '{32'h009, 16'h8841, 16'h1234, 64'habcd, 16'h0, 7'h0b, 1'b1},
      '{32'h009, 16'h8841, 16'h1234, 64'habce, 16'h0, 7'h0b, 1'b0},
      '{32'h009, 16'h8841, 16'h1234, 64'habcd, 16'h0, 7'h0a, 1'b0},
      '{32'h001, 16'h8841, 16'h1234, 64'habcd, 16'h0, 7'h0b, 1'b0},
      '{32'h009, 16'h8841, 16'hffff, 64'hffff, 16'h0, 7'h0b, 1'b1},
      '{32'h009, 16'h0c01, 16'h1234, 64'h0102030405060708, 16'h0, 7'h0f, 1'b1},
      '{32'h009, 16'h0c01, 16'h1234, 64'h0102030405060709, 16'h0, 7'h0f, 1'b0},
      '{32'h009, 16'h8841, 16'h1235, 64'habcd, 16'h0, 7'h0b, 1'b0},
      '{32'h009, 16'h0401, 16'h1234, 64'habcd, 16'h0, 7'h0b, 1'b0},
      '{32'h005, 16'h8000, 16'h0, 64'h0, 16'h1234, 7'h09, 1'b1},
      '{32'h001, 16'h8000, 16'h0, 64'h0, 16'h1234, 7'h09, 1'b0},
      '{32'h011, 16'h0002, 16'h0, 64'h0, 16'h0, 7'h05, 1'b1},
      '{32'h001, 16'h0002, 16'h0, 64'h0, 16'h0, 7'h05, 1'b0},
      '{32'h021, 16'h8843, 16'h1234, 64'habcd, 16'h0, 7'h0b, 1'b1},
      '{32'h001, 16'h8843, 16'h1234, 64'habcd, 16'h0, 7'h0b, 1'b0},
      '{32'h00b, 16'h8001, 16'h0, 64'h0, 16'h1234, 7'h09, 1'b1},
      '{32'h00b, 16'h8001, 16'h0, 64'h0, 16'h1235, 7'h09, 1'b0},
      '{32'h009, 16'h8001, 16'h0, 64'h0, 16'h1234, 7'h09, 1'b0},
      '{32'h081, 16'h8844, 16'h0, 64'h5, 16'h0, 7'h0b, 1'b1},
      '{32'h001, 16'h0004, 16'h0, 64'h0, 16'h0, 7'h05, 1'b0},
      '{32'h081, 16'h0005, 16'h0, 64'h0, 16'h0, 7'h05, 1'b0},
      '{32'h101, 16'h0005, 16'h0, 64'h0, 16'h0, 7'h05, 1'b1},
      '{32'h041, 16'h0005, 16'h0, 64'h0, 16'h0, 7'h05, 1'b1},
      '{32'h001, 16'h0006, 16'h0, 64'h0, 16'h0, 7'h05, 1'b0},
      '{32'h041, 16'h0007, 16'h0, 64'h0, 16'h0, 7'h04, 1'b0}
    };
    arst_n_in = 1'b0;
    psel_in = 1'b0;
    penable_in = 1'b0;
    pwrite_in = 1'b0;
    paddr_in = 12'h000;
    pwdata_in = 32'h0000_0000;
    repeat (3) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rdchk(A_CFG, 32'h0000_0000);
    rdchk(A_PAN, 32'hffff_ffff);
    rdchk(A_EUL, 32'h0000_0000);
    rdchk(A_STA, 32'h0000_0000);
    apb(1'b1, A_CFG, 32'hffff_ffff);
    rdchk(A_CFG, 32'h0000_01ff);
    apb(1'b0, 12'h008, 32'h0000_0000);
    check(rd, 32'h0000_0000);
    check({31'h0, er}, 32'h0000_0001);
    apb(1'b1, A_CFG, 32'h0000_0000);
    apb(1'b1, A_PAN, 32'h1234_abcd);
    apb(1'b1, A_EUL, 32'h0506_0708);
    apb(1'b1, A_EUH, 32'h0102_0304);
    apb(1'b1, A_STA, 32'hffff_ffff);
    rdchk(A_PAN, 32'h1234_abcd);
    rdchk(A_EUH, 32'h0102_0304);
    rdchk(A_STA, 32'h0000_0000);
    foreach (rows[i]) begin
      apb(1'b1, A_CFG, rows[i].cfg);
      m.put(rows[i].fc, rows[i].dpan, rows[i].dad, rows[i].span, rows[i].len);
      m.idle();
      verdict(rows[i].acc);
    end
    @(posedge sys_clk_in);
    #1;
    check({31'h0, vrd_valid_out}, 32'h0000_0000);
    // Back-to-back frames, one verdict per cycle
    apb(1'b1, A_CFG, 32'h0000_0009);
    m.put(16'h8841, 16'h1234, 64'habcd, 16'h0000, 7'h0b);
    m.put(16'h8841, 16'h1234, 64'h0bcd, 16'h0000, 7'h0b);
    verdict(1'b1);
    m.idle();
    verdict(1'b0);
    rdchk(A_STA, {rej_n[15:0], acc_n[15:0]});
    // Second reset in mid-run
    @(posedge sys_clk_in);
    arst_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    arst_n_in <= 1'b1;
    rdchk(A_CFG, 32'h0000_0000);
    rdchk(A_PAN, 32'hffff_ffff);
    rdchk(A_STA, 32'h0000_0000);
    tally_and_finish();
  end
endmodule
